// *** logic/tdvc_lane_cmp.sv ***
// masked per-bit data comparison
`default_nettype none
module tdvc_lane_cmp #(
   parameter int W = 32
) (
   input  wire logic [W-1:0] acc,
   input  wire logic [W-1:0] val,
   input  wire logic [W-1:0] mask,
   output logic              hit
);
   logic [W-1:0] bit_ok;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign bit_ok[i] = mask[i] | (acc[i] == val[i]);
      end
   endgenerate
   assign hit = &bit_ok;
endmodule
`default_nettype wire

// *** logic/tdvc_params.svh ***
// constants for the trace data value comparator
`ifndef TDVC_PARAMS_SVH
`define TDVC_PARAMS_SVH
`define TDVC_SIZE_BYTE  2'h0
`define TDVC_SIZE_HALF  2'h1
`define TDVC_SIZE_WORD  2'h3
`define TDVC_VER_V1     2'h0
`define TDVC_VER_V2     2'h1
`define TDVC_VER_V33    2'h2
`define TDVC_DATA_W     32
`endif

// *** logic/tdvc_pkg.sv ***
// types for the trace data value comparator
`default_nettype none
`include "tdvc_params.svh"
package tdvc_pkg;
   typedef enum logic [1:0] {
      TDVC_IDLE,
      TDVC_LSM
   } tdvc_state_t;
   typedef struct packed {
      logic        valid;
      logic        lsm_start;
      logic [3:0]  lsm_words;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] data;
   } tdvc_access_t;
   typedef struct packed {
      logic [1:0]  version;
      logic [1:0]  cmp_size;
      logic        range_mode;
      logic        big_endian;
      logic [31:0] address_compare_value_reg;
      logic [31:0] address_compare_high_reg;
      logic [31:0] data_compare_value_reg;
      logic [31:0] data_compare_mask_reg;
   } tdvc_config_t;
endpackage
`default_nettype wire

// *** logic/tdvc_top.sv ***
// trace data value comparator top level
// ----------------------------------------
// How it works
// - accesses are word, halfword, byte; multiples split
// - access value width follows access size
// - value register is 32 bits, software consistent
// - pre-3.3 smaller accesses still compared
// - v1 compares raw bus lanes
// - v1 no byte/halfword compare in ranges
// - v2-3.2 compares data rotated to bit 0
// - from 3.1 unaligned accesses accepted
// - v3.3 byte size: covering accesses match
// - halfword size: aligned covering accesses match
// - halfword size: misaligned overlaps never match
// - word size: only exact word access matches
// - v3.3 single: smaller access never matches
// - misaligned accesses for size are rejected
// - range uses low comparator for value
// - range: addr ge low and addr not ge high
// - range with value: sizes must be equal
// ----------------------------------------
`default_nettype none
`include "tdvc_params.svh"
module tdvc_top
   import tdvc_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire tdvc_access_t acc_in,
   input  wire tdvc_config_t cfg,
   output logic              lsm_busy,
   output logic              addr_match,
   output logic              value_match,
   output logic              cmp_match
);
   // ----------------------------------------
   // load/store multiple splitting
   // ----------------------------------------
   // a multi-word transfer arrives as one request; later words are
   // presented at successive word addresses, with the data of each beat
   // taken straight from the core since nothing here needs to hold it
   // the core's own address on later beats is ignored: the generated
   // address is the one the trace would report
   tdvc_state_t  state_r, state_nxt;
   logic [3:0]   left_r, left_nxt;
   logic [31:0]  lsm_addr_r, lsm_addr_nxt;
   tdvc_access_t cur;

   always_comb begin
      state_nxt    = state_r;
      left_nxt     = left_r;
      lsm_addr_nxt = lsm_addr_r;
      cur          = acc_in;
      unique case (state_r)
         TDVC_IDLE: begin
            if (acc_in.valid && acc_in.lsm_start && acc_in.lsm_words > 4'h1) begin
               cur.size     = `TDVC_SIZE_WORD;
               state_nxt    = TDVC_LSM;
               left_nxt     = acc_in.lsm_words - 4'h1;
               lsm_addr_nxt = acc_in.addr + 32'h4;
            end
         end
         TDVC_LSM: begin
            cur.valid = acc_in.valid;
            cur.size  = `TDVC_SIZE_WORD;
            cur.addr  = lsm_addr_r;
            // a cycle without valid is a core stall; the beat count waits
            if (acc_in.valid) begin
               lsm_addr_nxt = lsm_addr_r + 32'h4;
               left_nxt     = left_r - 4'h1;
               if (left_r == 4'h1) begin
                  state_nxt = TDVC_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_r    <= TDVC_IDLE;
         left_r     <= 4'h0;
         lsm_addr_r <= 32'h0;
      end else begin
         state_r    <= state_nxt;
         left_r     <= left_nxt;
         lsm_addr_r <= lsm_addr_nxt;
      end
   end

   // ----------------------------------------
   // access value shaping per version
   // ----------------------------------------
   logic [1:0]  off;
   logic [31:0] acc_val;
   logic [31:0] lane_val;
   logic [4:0]  rot;

   assign off = cur.addr[1:0];

   always_comb begin
      lane_val = cur.data;
      rot      = 5'h0;
      acc_val  = cur.data;
      unique case (cfg.version)
         `TDVC_VER_V1: begin
            acc_val = cur.data;
         end
         `TDVC_VER_V2: begin
            // rotate the lane down so small accesses sit at bit 0
            // big endian lanes count from the top byte, so the shift is
            // measured from the far end of the word
            rot = cfg.big_endian ? 5'(({3'h0, ~off} - {1'b0, cur.size} - 5'h0) << 3)
                                 : 5'({off, 3'h0});
            if (cur.size == `TDVC_SIZE_WORD) begin
               rot = 5'h0;
            end
            lane_val = cur.data >> rot;
            // upper lanes keep whatever the bus held: unpredictable
            acc_val  = (cur.size == `TDVC_SIZE_WORD) ? cur.data :
                       {cur.data[31:16], lane_val[15:0]};
            if (cur.size == `TDVC_SIZE_BYTE) begin
               acc_val = {cur.data[31:8], lane_val[7:0]};
            end
         end
         default: begin
            acc_val = cur.data;
         end
      endcase
   end

   // ----------------------------------------
   // masked value comparison
   // ----------------------------------------
   // the full-width compare serves word sizes, ranges and older versions,
   // where the shaped access value already sits in place
   logic raw_hit;
   tdvc_lane_cmp #(
      .W (`TDVC_DATA_W)
   ) u_cmp (
      .acc  (acc_val),
      .val  (cfg.data_compare_value_reg),
      .mask (cfg.data_compare_mask_reg),
      .hit  (raw_hit)
   );

   // v3.3 replicated compare: any byte/halfword lane of the access
   // overlapping the comparison address decides the match
   logic [3:0] byte_hit;
   logic [1:0] half_hit;
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_byte
         assign byte_hit[b] = &(cfg.data_compare_mask_reg[8*b +: 8] |
                                ~(cur.data[8*b +: 8] ^ cfg.data_compare_value_reg[8*b +: 8]));
      end
      for (b = 0; b < 2; b++) begin : g_half
         assign half_hit[b] = &(cfg.data_compare_mask_reg[16*b +: 16] |
                                ~(cur.data[16*b +: 16] ^
                                  cfg.data_compare_value_reg[16*b +: 16]));
      end
   endgenerate

   // ----------------------------------------
   // address qualification
   // ----------------------------------------
   logic [31:0] ca;
   logic [31:0] base;
   logic [31:0] diff;
   logic        lo_ge;
   logic        hi_ge;
   logic        range_hit;
   logic        single_hit;
   logic        v33_hit;
   logic        val_ok;
   logic        aligned;
   logic [1:0]  byte_lane;
   logic        half_lane;

   assign ca       = cfg.address_compare_value_reg;
   assign base     = {cur.addr[31:2], 2'h0};
   assign diff     = ca - cur.addr;
   assign lo_ge    = cur.addr >= ca;
   assign hi_ge    = cur.addr >= cfg.address_compare_high_reg;
   assign range_hit = lo_ge && !hi_ge;
   // from 3.1 unaligned accesses compare on their own address
   assign single_hit = (cur.addr == ca) ||
                       (cfg.version == `TDVC_VER_V1 && base == {ca[31:2], 2'h0});

   // the compared unit sits on the bus lane of the comparison address;
   // the lane order flips with endianness, while replication in the value
   // and mask registers makes the register side the same on every lane
   assign byte_lane = cfg.big_endian ? ~ca[1:0] : ca[1:0];
   assign half_lane = cfg.big_endian ? ~ca[1] : ca[1];

   // alignment is judged against the comparison size, not the access size

   always_comb begin
      aligned = 1'b1;
      unique case (cfg.cmp_size)
         `TDVC_SIZE_HALF: aligned = ~cur.addr[0];
         `TDVC_SIZE_WORD: aligned = (cur.addr[1:0] == 2'h0);
         default:         aligned = 1'b1;
      endcase
   end

   always_comb begin
      v33_hit = 1'b0;
      unique case (cfg.cmp_size)
         `TDVC_SIZE_BYTE: begin
            // diff is how far the access starts below the comparison address;
            // a start above it wraps to a huge value and misses every window
            unique case (cur.size)
               `TDVC_SIZE_BYTE: v33_hit = (diff == 32'h0) && byte_hit[byte_lane];
               `TDVC_SIZE_HALF: v33_hit = (diff < 32'h2) && byte_hit[byte_lane];
               `TDVC_SIZE_WORD: v33_hit = (diff < 32'h4) && byte_hit[byte_lane];
               default:         v33_hit = 1'b0;
            endcase
         end
         `TDVC_SIZE_HALF: begin
            unique case (cur.size)
               `TDVC_SIZE_HALF: v33_hit = (diff == 32'h0) && half_hit[half_lane];
               `TDVC_SIZE_WORD: v33_hit = aligned && half_hit[half_lane] &&
                                          ((diff == 32'h0) || (diff == 32'h2));
               default:         v33_hit = 1'b0;
            endcase
         end
         `TDVC_SIZE_WORD: begin
            v33_hit = (cur.size == `TDVC_SIZE_WORD) && (diff == 32'h0) && raw_hit;
         end
         default: v33_hit = 1'b0;
      endcase
      if (!aligned) begin
         v33_hit = 1'b0;
      end
   end

   // before 3.3 the value test is independent of the address test and the
   // two are combined at the output; from 3.3 single compares fold both
   always_comb begin
      val_ok = raw_hit;
      if (cfg.version == `TDVC_VER_V33) begin
         if (cfg.range_mode) begin
            val_ok = aligned && (cur.size == cfg.cmp_size) && raw_hit;
         end else begin
            val_ok = v33_hit;
         end
      end else if (cfg.version == `TDVC_VER_V1 && cfg.range_mode &&
                   cfg.cmp_size != `TDVC_SIZE_WORD) begin
         val_ok = 1'b0;
      end
   end

   // ----------------------------------------
   // registered results
   // ----------------------------------------
   logic addr_nxt;
   logic value_nxt;
   logic match_nxt;
   logic busy_nxt;

   // results describe the access taken at the previous edge and stand for
   // one cycle; an idle cycle clears them so a match is never stretched
   always_comb begin
      addr_nxt  = 1'b0;
      value_nxt = 1'b0;
      match_nxt = 1'b0;
      busy_nxt  = (state_nxt == TDVC_LSM);
      if (cur.valid) begin
         if (cfg.range_mode) begin
            addr_nxt = range_hit;
         end else if (cfg.version == `TDVC_VER_V33) begin
            // overlap windows already include the address test
            addr_nxt = single_hit || (diff < 32'h4);
         end else begin
            addr_nxt = single_hit;
         end
         value_nxt = val_ok;
         match_nxt = (cfg.version == `TDVC_VER_V33 && !cfg.range_mode) ? v33_hit
                                                                       : addr_nxt && val_ok;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         addr_match  <= 1'b0;
         value_match <= 1'b0;
         cmp_match   <= 1'b0;
         lsm_busy    <= 1'b0;
      end else begin
         addr_match  <= addr_nxt;
         value_match <= value_nxt;
         cmp_match   <= match_nxt;
         lsm_busy    <= busy_nxt;
      end
   end
endmodule
`default_nettype wire

// *** tb/tdvc_core_model.sv ***
// model of the traced core's data side, one access per cycle
`default_nettype none
module tdvc_core_model
   import tdvc_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire tdvc_access_t req,
   output var  tdvc_access_t acc
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] last_r;
   logic [31:0] last_nxt;
   always_comb begin
      acc      = req;
      last_nxt = req.valid ? req.data : last_r;
      // released bus shows the inverse so a stale value can never pass for live data
      if (!req.valid) begin
         acc.data = ~last_r;
         acc.addr = ~req.addr;
      end
   end
   always_ff @(posedge ref_clk) begin
      last_r <= rst_n ? last_nxt : 32'h0;
   end
endmodule
`default_nettype wire

// *** tb/tdvc_monitor.sv ***
// port checker for the trace data value comparator
`default_nettype none
`include "tdvc_params.svh"
module tdvc_monitor
   import tdvc_pkg::*;
(
   input wire logic         ref_clk,
   input wire logic         rst_n,
   input wire tdvc_access_t acc_in,
   input wire tdvc_config_t cfg,
   input wire logic         lsm_busy,
   input wire logic         addr_match,
   input wire logic         value_match,
   input wire logic         cmp_match
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic tk;
   logic v3;
   logic dok;
   logic [31:0] a;
   assign a  = acc_in.addr;
   assign v3 = cfg.version == `TDVC_VER_V33;
   assign tk = acc_in.valid && !acc_in.lsm_start && !lsm_busy;
   assign dok = ((acc_in.data ^ cfg.data_compare_value_reg) & ~cfg.data_compare_mask_reg) == '0;
   sequence lsm_run;
      lsm_busy [*2] ##1 !lsm_busy;
   endsequence
   idle_quiet_a: assert property (!acc_in.valid && !lsm_busy |=> !cmp_match)
      else $error("match without access");
   lsm_beats_a: assert property (acc_in.valid && acc_in.lsm_start && acc_in.lsm_words == 4'h3
      && !lsm_busy |=> lsm_run) else $error("multiple busy length wrong");
   word_exact_a: assert property (tk && v3 && !cfg.range_mode && cfg.cmp_size == `TDVC_SIZE_WORD
      && acc_in.size == `TDVC_SIZE_WORD && a == cfg.address_compare_value_reg
      |=> cmp_match == $past(dok)) else $error("word match wrong");
   word_addr_a: assert property (tk && v3 && !cfg.range_mode && cfg.cmp_size == `TDVC_SIZE_WORD
      && a != cfg.address_compare_value_reg |=> !cmp_match) else $error("word other address");
   small_size_a: assert property (tk && v3 && !cfg.range_mode && acc_in.size < cfg.cmp_size
      |=> !cmp_match) else $error("small access matched");
   word_align_a: assert property (tk && v3 && cfg.cmp_size == `TDVC_SIZE_WORD && a[1:0] != 2'h0
      |=> !cmp_match) else $error("misaligned word matched");
   half_align_a: assert property (tk && v3 && cfg.cmp_size == `TDVC_SIZE_HALF && a[0]
      |=> !cmp_match) else $error("misaligned half matched");
   range_size_a: assert property (tk && v3 && cfg.range_mode && acc_in.size != cfg.cmp_size
      |=> !cmp_match) else $error("range size mismatch matched");
   range_out_a: assert property (tk && cfg.range_mode && (a < cfg.address_compare_value_reg
      || a >= cfg.address_compare_high_reg) |=> !cmp_match) else $error("range outside matched");
endmodule
bind tdvc_top tdvc_monitor tdvc_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n), .acc_in(acc_in),
   .cfg(cfg), .lsm_busy(lsm_busy), .addr_match(addr_match), .value_match(value_match),
   .cmp_match(cmp_match));
`default_nettype wire

// *** tb/tdvc_top_tb.sv ***
// testbench for the trace data value comparator
`default_nettype none
`include "tdvc_params.svh"
module tdvc_top_tb
   import tdvc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] sb = `TDVC_SIZE_BYTE;
   localparam logic [1:0] sh = `TDVC_SIZE_HALF;
   localparam logic [1:0] sw = `TDVC_SIZE_WORD;
   localparam logic [1:0] v1 = `TDVC_VER_V1;
   localparam logic [1:0] v2 = `TDVC_VER_V2;
   localparam logic [1:0] v3 = `TDVC_VER_V33;
   logic         ref_clk = 1'b0;
   logic         rst_n   = 1'b0;
   tdvc_access_t req     = '0;
   tdvc_access_t acc;
   tdvc_config_t cfg     = '0;
   logic         lsm_busy, addr_match, value_match, cmp_match;
   int           n_fail      = 0;
   int           check_count = 0;
   always #25 ref_clk = ~ref_clk;
   tdvc_core_model tdvc_core_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .acc(acc));
   tdvc_top tdvc_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .acc_in(acc), .cfg(cfg),
      .lsm_busy(lsm_busy), .addr_match(addr_match), .value_match(value_match),
      .cmp_match(cmp_match));
   // ------------------------------------------
   // shared drivers and comparison
   // ------------------------------------------
   task automatic chk(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask
   task automatic setc(input logic [1:0] ver, input logic [1:0] csz, input logic rng,
      input logic [31:0] ca, input logic [31:0] hi, input logic [31:0] dv, input logic [31:0] dm);
      @(posedge ref_clk);
      cfg <= '{ver, csz, rng, 1'b0, ca, hi, dv, dm};
   endtask
   task automatic ac(input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d,
      input logic exp);
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, 4'h0, sz, a, d};
      @(posedge ref_clk);
      req.valid <= 1'b0;
      @(negedge ref_clk);
      chk(cmp_match, exp);
   endtask
   task automatic ac_all(input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d,
      input logic exp_addr, input logic exp_val, input logic exp_match);
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, 4'h0, sz, a, d};
      @(posedge ref_clk);
      req.valid <= 1'b0;
      @(negedge ref_clk);
      chk(addr_match, exp_addr);
      chk(value_match, exp_val);
      chk(cmp_match, exp_match);
   endtask
   task automatic t_byte();
      setc(v3, sb, 1'b0, 32'h2002, 32'h0, 32'habababab, 32'h0);
      ac(sb, 32'h2002, 32'habababab, 1'b1);
      ac(sh, 32'h2002, 32'habababab, 1'b1);
      ac(sw, 32'h2000, 32'habababab, 1'b1);
      ac(sh, 32'h2001, 32'habababab, 1'b1);
      ac(sh, 32'h2000, 32'habababab, 1'b0);
      ac(sb, 32'h2003, 32'habababab, 1'b0);
      ac(sb, 32'h2002, 32'hab00abab, 1'b0);
      setc(v3, sb, 1'b0, 32'h2002, 32'h0, 32'habababab, 32'h0f0f0f0f);
      ac(sb, 32'h2002, 32'h00a50000, 1'b1);
      ac(sb, 32'h2002, 32'h005b0000, 1'b0);
      $display("byte size done");
   endtask
   task automatic t_half();
      setc(v3, sh, 1'b0, 32'h2004, 32'h0, 32'h12341234, 32'h0);
      ac(sh, 32'h2004, 32'h12341234, 1'b1);
      ac(sw, 32'h2004, 32'h12341234, 1'b1);
      ac(sw, 32'h2002, 32'h12341234, 1'b1);
      ac(sh, 32'h2005, 32'h12341234, 1'b0);
      ac(sw, 32'h2003, 32'h12341234, 1'b0);
      ac(sb, 32'h2004, 32'h12341234, 1'b0);
      $display("half size done");
   endtask
   task automatic t_word();
      setc(v3, sw, 1'b0, 32'h2008, 32'h0, 32'hcafe0123, 32'h0);
      ac(sw, 32'h2008, 32'hcafe0123, 1'b1);
      ac(sw, 32'h2008, 32'hcafe0124, 1'b0);
      ac(sw, 32'h200c, 32'hcafe0123, 1'b0);
      ac(sh, 32'h2008, 32'hcafe0123, 1'b0);
      ac(sw, 32'h200a, 32'hcafe0123, 1'b0);
      ac_all(sw, 32'h2008, 32'hcafe0124, 1'b1, 1'b0, 1'b0);
      setc(v3, sw, 1'b0, 32'h2008, 32'h0, 32'hcafe0123, 32'h0000000f);
      ac(sw, 32'h2008, 32'hcafe0124, 1'b1);
      $display("word size done");
   endtask
   task automatic t_range();
      setc(v3, sw, 1'b1, 32'h3000, 32'h3010, 32'h55aa55aa, 32'h0);
      ac(sw, 32'h3004, 32'h55aa55aa, 1'b1);
      ac(sw, 32'h3010, 32'h55aa55aa, 1'b0);
      ac(sw, 32'h2ffc, 32'h55aa55aa, 1'b0);
      ac(sh, 32'h3004, 32'h55aa55aa, 1'b0);
      ac(sw, 32'h3006, 32'h55aa55aa, 1'b0);
      ac_all(sw, 32'h3010, 32'h55aa55aa, 1'b0, 1'b1, 1'b0);
      ac_all(sw, 32'h3008, 32'h00000000, 1'b1, 1'b0, 1'b0);
      $display("range done");
   endtask
   task automatic t_old();
      setc(v2, sb, 1'b0, 32'h2001, 32'h0, 32'h000000ab, 32'hffffff00);
      ac(sb, 32'h2001, 32'h0000ab00, 1'b1);
      ac(sb, 32'h2001, 32'h0000cd00, 1'b0);
      setc(v2, sw, 1'b0, 32'h2000, 32'h0, 32'h000000ab, 32'hffffff00);
      ac(sb, 32'h2000, 32'h000000ab, 1'b1);
      setc(v1, sb, 1'b0, 32'h2001, 32'h0, 32'h0000ab00, 32'hffff00ff);
      ac(sb, 32'h2001, 32'h0000ab00, 1'b1);
      ac(sb, 32'h2001, 32'h000000ab, 1'b0);
      ac_all(sb, 32'h2001, 32'h000000ab, 1'b1, 1'b0, 1'b0);
      setc(v1, sb, 1'b1, 32'h2000, 32'h2010, 32'h0000ab00, 32'hffff00ff);
      ac(sb, 32'h2001, 32'h0000ab00, 1'b0);
      ac_all(sb, 32'h2001, 32'h0000ab00, 1'b1, 1'b0, 1'b0);
      $display("older versions done");
   endtask
   task automatic t_endian();
      setc(v2, sb, 1'b0, 32'h2002, 32'h0, 32'h000000ab, 32'hffffff00);
      @(posedge ref_clk);
      cfg.big_endian <= 1'b1;
      ac(sb, 32'h2002, 32'h0000ab00, 1'b1);
      ac(sb, 32'h2002, 32'h00ab0000, 1'b0);
      setc(v2, sh, 1'b0, 32'h2002, 32'h0, 32'h00001234, 32'hffff0000);
      ac(sh, 32'h2002, 32'h12340000, 1'b1);
      setc(v3, sb, 1'b0, 32'h2002, 32'h0, 32'habababab, 32'h0);
      @(posedge ref_clk);
      cfg.big_endian <= 1'b1;
      ac(sb, 32'h2002, 32'hab00abab, 1'b1);
      ac(sw, 32'h2000, 32'h00ab0000, 1'b0);
      $display("endian done");
   endtask
   task automatic t_lsm();
      setc(v3, sw, 1'b0, 32'h4008, 32'h0, 32'h55aa55aa, 32'h0);
      @(posedge ref_clk);
      req <= '{1'b1, 1'b1, 4'h3, sw, 32'h4000, 32'h11111111};
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, 4'h0, sw, 32'h4004, 32'h22222222};
      @(negedge ref_clk);
      chk(lsm_busy, 1'b1);
      chk(cmp_match, 1'b0);
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, 4'h0, sw, 32'h4008, 32'h55aa55aa};
      @(negedge ref_clk);
      chk(cmp_match, 1'b0);
      @(posedge ref_clk);
      req.valid <= 1'b0;
      @(negedge ref_clk);
      chk(cmp_match, 1'b1);
      chk(lsm_busy, 1'b0);
      $display("multiple done");
   endtask
   task automatic t_reset();
      @(posedge ref_clk);
      req <= '{1'b1, 1'b1, 4'h3, sw, 32'h4000, 32'h11111111};
      @(posedge ref_clk);
      req   <= '0;
      rst_n <= 1'b0;
      @(negedge ref_clk);
      chk(lsm_busy, 1'b1);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(lsm_busy, 1'b0);
      chk(cmp_match, 1'b0);
      @(posedge ref_clk);
      rst_n <= 1'b1;
      ac(sw, 32'h4008, 32'h55aa55aa, 1'b1);
      $display("reset done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_byte();
      t_half();
      t_word();
      t_range();
      t_old();
      t_endian();
      t_lsm();
      t_reset();
      complete_run();
   end
endmodule
`default_nettype wire
